// >>> rtl/ppm_defs.svh
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
`define PPM_REG_ADDR        7'h33
`define PPM_REG_RESET       8'h00
`define PPM_OVLD_SEL_HI     7
`define PPM_OVLD_SEL_LO     6
`define PPM_SURGE_EN_BIT    5
`define PPM_SAG_EN_BIT      4
`define PPM_OVLD_FLAG_BIT   3
`define PPM_RELAX_FLAG_BIT  2
`define PPM_PERIOD_HI       1
`define PPM_PERIOD_LO       0
`define PPM_CLK_HZ          40000000
`define PPM_OVLD_T0_MS      1
`define PPM_OVLD_T1_MS      2
`define PPM_OVLD_T2_MS      5
`define PPM_OVLD_T3_MS      10
`define PPM_PERIOD_T0_MS    20
`define PPM_PERIOD_T1_MS    40
`define PPM_PERIOD_T2_MS    60
`define PPM_PERIOD_T3_MS    80
`define PPM_CYC_PER_MS      (`PPM_CLK_HZ / 1000)
`endif

// >>> rtl/ppm_pkg.sv
`default_nettype none
package ppm_pkg;
   typedef enum logic [1:0] {
      PPM_IDLE,
      PPM_OVERLOAD,
      PPM_RELAX
   } ppm_state_t;
   typedef logic [23:0] ppm_count_t;
endpackage : ppm_pkg
`default_nettype wire

// >>> rtl/ppm_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppm_timer_if;
   logic                 load;
   ppm_pkg::ppm_count_t  limit;
   logic                 expired;
   modport ctrl (output load, output limit, input expired);
   modport tmr  (input load, input limit, output expired);
endinterface : ppm_timer_if
`default_nettype wire

// >>> rtl/ppm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_timer
   import ppm_pkg::*;
(
   input  wire logic  i_ref_clk,
   input  wire logic  i_rstn,
   ppm_timer_if.tmr   tif
);
   ppm_count_t count;

   // Restarts on load; expired holds once the limit is reached
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         count <= '0;
      end else if (tif.load) begin
         count <= '0;
      end else if (count < tif.limit) begin
         count <= count + 24'h000001;
      end
   end

   assign tif.expired = !tif.load && (count >= tif.limit);
endmodule : ppm_timer
`default_nettype wire

// >>> rtl/ppm_ctrl.sv
`timescale 1ns/1ps
`include "ppm_defs.svh"
`default_nettype none
module ppm_ctrl
   import ppm_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   input  wire logic [6:0]  i_addr,
   input  wire logic        i_wr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_reg_restore,
   input  wire logic        i_adapter_present,
   input  wire logic        i_surge_detect,
   input  wire logic        i_rail_sag_detect,
   output var  logic [7:0]  o_rdata,
   output var  logic        o_peak_active,
   output var  logic        o_overload_active,
   output var  logic        o_relax_active
);
   logic [1:0]  overload_time_select;
   logic        surge_trigger_enable;
   logic        rail_sag_trigger_enable;
   logic [1:0]  cycle_period_select;
   ppm_state_t  state;
   ppm_state_t  state_prev;
   logic        state_moved;
   ppm_count_t  hold_limit;
   ppm_count_t  relax_limit;
   logic        trigger;
   logic        hit;
   logic        adapter_prev;
   logic        adapter_gone;
   ppm_timer_if tif ();

   function automatic ppm_count_t ms_to_cycles(input int ms);
      ms_to_cycles = ppm_count_t'(ms * `PPM_CYC_PER_MS);
   endfunction : ms_to_cycles

   ppm_timer u_timer (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .tif       (tif)
   );

   assign hit = i_wr && (i_addr == `PPM_REG_ADDR);
   assign adapter_gone = adapter_prev && !i_adapter_present;
   assign state_moved  = state != state_prev;
   assign trigger = (surge_trigger_enable && i_surge_detect)
                 || (rail_sag_trigger_enable && i_rail_sag_detect);

   always_comb begin
      case (overload_time_select)
         2'h0:    hold_limit = ms_to_cycles(`PPM_OVLD_T0_MS);
         2'h1:    hold_limit = ms_to_cycles(`PPM_OVLD_T1_MS);
         2'h2:    hold_limit = ms_to_cycles(`PPM_OVLD_T2_MS);
         default: hold_limit = ms_to_cycles(`PPM_OVLD_T3_MS);
      endcase
   end

   // Relax phase fills the remainder of the combined period
   always_comb begin
      case (cycle_period_select)
         2'h0:    relax_limit = ms_to_cycles(`PPM_PERIOD_T0_MS);
         2'h1:    relax_limit = ms_to_cycles(`PPM_PERIOD_T1_MS);
         2'h2:    relax_limit = ms_to_cycles(`PPM_PERIOD_T2_MS);
         default: relax_limit = ms_to_cycles(`PPM_PERIOD_T3_MS);
      endcase
      relax_limit = (relax_limit > hold_limit) ? relax_limit - hold_limit : 24'h000001;
   end

   // Timer restarts in the cycle after every state change and while idle without a trigger;
   // overload phase lasts the overload time, relax phase the rest of the period
   always_comb begin
      tif.limit = (state == PPM_RELAX) ? relax_limit : hold_limit;
      tif.load  = 1'b0;
      case (state)
         PPM_IDLE:     tif.load = !trigger;
         PPM_OVERLOAD: tif.load = 1'b0;
         PPM_RELAX:    tif.load = 1'b0;
         default:      tif.load = 1'b1;
      endcase
      if (i_reg_restore || adapter_gone || state_moved) begin
         tif.load = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_prev <= PPM_IDLE;
      end else begin
         state_prev <= state;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         adapter_prev <= 1'b0;
      end else begin
         adapter_prev <= i_adapter_present;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         overload_time_select    <= 2'h0;
         surge_trigger_enable    <= 1'b0;
         rail_sag_trigger_enable <= 1'b0;
         cycle_period_select     <= 2'h0;
      end else if (i_reg_restore) begin
         overload_time_select    <= 2'h0;
         surge_trigger_enable    <= 1'b0;
         rail_sag_trigger_enable <= 1'b0;
         cycle_period_select     <= 2'h0;
      end else begin
         if (hit) begin
            overload_time_select    <= i_wdata[`PPM_OVLD_SEL_HI:`PPM_OVLD_SEL_LO];
            surge_trigger_enable    <= i_wdata[`PPM_SURGE_EN_BIT];
            rail_sag_trigger_enable <= i_wdata[`PPM_SAG_EN_BIT];
            cycle_period_select     <= i_wdata[`PPM_PERIOD_HI:`PPM_PERIOD_LO];
         end
         // Removal beats a simultaneous write so a stale enable cannot survive
         if (adapter_gone) begin
            surge_trigger_enable    <= 1'b0;
            rail_sag_trigger_enable <= 1'b0;
         end
      end
   end

   // Writing one to a flag has no effect; only hardware enters a cycle
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= PPM_IDLE;
      end else if (i_reg_restore || adapter_gone) begin
         state <= PPM_IDLE;
      end else begin
         case (state)
            PPM_IDLE: begin
               if (trigger && tif.expired) begin
                  state <= PPM_OVERLOAD;
               end
            end
            PPM_OVERLOAD: begin
               if (hit && !i_wdata[`PPM_OVLD_FLAG_BIT]) begin
                  state <= PPM_IDLE;
               end else if (tif.expired) begin
                  state <= PPM_RELAX;
               end
            end
            PPM_RELAX: begin
               if (hit && !i_wdata[`PPM_RELAX_FLAG_BIT]) begin
                  state <= PPM_IDLE;
               end else if (tif.expired) begin
                  state <= PPM_IDLE;
               end
            end
            default: state <= PPM_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata           <= `PPM_REG_RESET;
         o_peak_active     <= 1'b0;
         o_overload_active <= 1'b0;
         o_relax_active    <= 1'b0;
      end else begin
         o_rdata <= (i_addr == `PPM_REG_ADDR) ?
            {overload_time_select, surge_trigger_enable, rail_sag_trigger_enable,
             state == PPM_OVERLOAD, state == PPM_RELAX,
             cycle_period_select} : 8'h00;
         o_peak_active     <= state != PPM_IDLE;
         o_overload_active <= state == PPM_OVERLOAD;
         o_relax_active    <= state == PPM_RELAX;
      end
   end

   property p_disabled_idle;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!surge_trigger_enable && !rail_sag_trigger_enable && state == PPM_IDLE)
         |=> state == PPM_IDLE;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) else $error("entry while disabled");

   property p_removal_clears;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      adapter_gone |=> !surge_trigger_enable && !rail_sag_trigger_enable;
   endproperty
   a_removal_clears: assert property (p_removal_clears) else $error("enables kept");

   property p_ovld_exit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (state == PPM_OVERLOAD && hit && !i_wdata[`PPM_OVLD_FLAG_BIT] && !i_reg_restore)
         |=> state == PPM_IDLE ##1 !o_overload_active;
   endproperty
   a_ovld_exit: assert property (p_ovld_exit) else $error("overload not left");

   property p_relax_exit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (state == PPM_RELAX && hit && !i_wdata[`PPM_RELAX_FLAG_BIT])
         |=> state == PPM_IDLE;
   endproperty
   a_relax_exit: assert property (p_relax_exit) else $error("relax not left");

   property p_flag_read;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_addr == `PPM_REG_ADDR)
         |=> o_rdata[`PPM_OVLD_FLAG_BIT] == $past(state == PPM_OVERLOAD)
          && o_rdata[`PPM_RELAX_FLAG_BIT] == $past(state == PPM_RELAX);
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag mismatch");

   property p_restore;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_reg_restore |=> {overload_time_select, surge_trigger_enable,
                         rail_sag_trigger_enable, cycle_period_select} == 6'h00
                        && state == PPM_IDLE;
   endproperty
   a_restore: assert property (p_restore) else $error("restore incomplete");

   sequence s_entry;
      state == PPM_IDLE ##1 state == PPM_OVERLOAD;
   endsequence

   property p_entry_needs_trigger;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      s_entry |-> $past(trigger);
   endproperty
   a_entry_needs_trigger: assert property (p_entry_needs_trigger) else $error("bad entry");

   property p_hold_limit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      overload_time_select == 2'h2 |-> hold_limit == 24'd200000;
   endproperty
   a_hold_limit: assert property (p_hold_limit) else $error("5 ms count wrong");

   property p_period0;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (cycle_period_select == 2'h0 && overload_time_select == 2'h0)
         |-> relax_limit == 24'd760000;
   endproperty
   a_period0: assert property (p_period0) else $error("20 ms period wrong");
endmodule : ppm_ctrl
`default_nettype wire

// >>> verif/ppm_env_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_env_model (
   input  wire logic i_ref_clk,
   input  wire logic i_surge_req,
   input  wire logic i_sag_req,
   input  wire logic i_plug_req,
   output var  logic o_surge_detect,
   output var  logic o_rail_sag_detect,
   output var  logic o_adapter_present
);
   // Comparators settle one clock after the analog condition changes
   always_ff @(posedge i_ref_clk) begin
      o_surge_detect    <= i_surge_req;
      o_rail_sag_detect <= i_sag_req;
      o_adapter_present <= i_plug_req;
   end
endmodule : ppm_env_model
`default_nettype wire

// >>> verif/peak_power_mode_control_bench.sv
`timescale 1ns/1ps
`include "ppm_defs.svh"
`default_nettype none
module peak_power_mode_control_bench;
   localparam int OVLD_CYC = `PPM_OVLD_T0_MS * `PPM_CYC_PER_MS;
   localparam logic [6:0] RA = `PPM_REG_ADDR;
   logic       clk, rstn, wr, restore, surge_q, sag_q, plug_q;
   logic       surge, sag, plug, peak, ovl, rlx;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   int         fail_count;
   int         n_compared;

   ppm_env_model ENV (.i_ref_clk(clk), .i_surge_req(surge_q), .i_sag_req(sag_q),
      .i_plug_req(plug_q), .o_surge_detect(surge), .o_rail_sag_detect(sag),
      .o_adapter_present(plug));
   ppm_ctrl DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr(wr),
      .i_wdata(wdata), .i_reg_restore(restore), .i_adapter_present(plug),
      .i_surge_detect(surge), .i_rail_sag_detect(sag), .o_rdata(rdata),
      .o_peak_active(peak), .o_overload_active(ovl), .o_relax_active(rlx));

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic chk1(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask : chk1

   task automatic reg_wr(input logic [7:0] d);
      @(posedge clk);
      addr  <= RA;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   // Read data lags the address by one edge, so allow two
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1;
      chk(name, exp, rdata);
   endtask : rd_chk

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      while ((sel == 0 ? ovl : rlx) !== 1'b1) begin
         idle(1);
         n++;
         if (n > lim) begin
            fail_count++;
            $display("CHECK FAILED wait%0d expected 1 seen timeout", sel);
            end_sim();
         end
      end
   endtask : wait_hi

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      rstn = 1'b0; wr = 1'b0; restore = 1'b0; addr = 7'h00; wdata = 8'h00;
      surge_q = 1'b0; sag_q = 1'b0; plug_q = 1'b1;
      fail_count = 0; n_compared = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(RA, 8'h00, "reset");
      rd_chk(7'h34, 8'h00, "unmapped");
      reg_wr(8'hff);
      rd_chk(RA, 8'hf3, "flags_ro");
      reg_wr(8'h81);
      rd_chk(RA, 8'h81, "sel_code2");
      @(posedge clk);
      restore <= 1'b1;
      @(posedge clk);
      restore <= 1'b0;
      rd_chk(RA, 8'h00, "restore");
      $display("test registers done");
      // Overload via current surge, cleared by software
      reg_wr(8'h20);
      surge_q <= 1'b1;
      idle(OVLD_CYC - 5);
      chk1("early_ovl", 1'b0, ovl);
      wait_hi(0, 20);
      chk1("peak", 1'b1, peak);
      rd_chk(RA, 8'h28, "ovl_flag");
      reg_wr(8'h28);
      idle(3);
      chk1("ovl_hold", 1'b1, ovl);
      reg_wr(8'h20);
      surge_q <= 1'b0;
      idle(3);
      chk1("ovl_clr", 1'b0, ovl);
      rd_chk(RA, 8'h20, "after_clr");
      $display("test overload done");
      // Overload via rail sag, then relax, cleared by software
      reg_wr(8'h10);
      sag_q <= 1'b1;
      wait_hi(0, OVLD_CYC + 20);
      idle(OVLD_CYC - 5);
      chk1("early_rlx", 1'b0, rlx);
      wait_hi(1, 20);
      chk1("ovl_off", 1'b0, ovl);
      rd_chk(RA, 8'h14, "rlx_flag");
      sag_q <= 1'b0;
      reg_wr(8'h10);
      idle(3);
      chk1("rlx_clr", 1'b0, rlx);
      chk1("peak_clr", 1'b0, peak);
      $display("test relax done");
      reg_wr(8'h30);
      plug_q <= 1'b0;
      idle(4);
      rd_chk(RA, 8'h00, "unplug");
      plug_q <= 1'b1;
      $display("test adapter done");
      end_sim();
   end
endmodule : peak_power_mode_control_bench
`default_nettype wire
